// file: bench/ibt_bus_partner.sv
`timescale 1ns/100ps
// local bus slave side: open-drain wires with pull-ups
module ibt_bus_partner (
  input wire logic i_scl_pull,
  input wire logic i_sda_pull,
  input wire logic i_hold_scl,
  input wire logic i_hold_sda,
  output logic o_scl,
  output logic o_sda
);
  assign o_scl = !(i_scl_pull || i_hold_scl);
  // slave may hang sda low
  assign o_sda = !(i_sda_pull || i_hold_sda);
endmodule

// file: bench/ibt_bus_timing_ctrl_chk.sv
`timescale 1ns/100ps
module ibt_chk (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire ibt_pkg::ibt_reg_req_type i_reg_req,
  input wire logic [7:0] o_reg_rdata,
  input wire logic i_sda,
  input wire logic o_scl,
  input wire logic o_sda,
  input wire logic o_scl_oe,
  input wire logic o_sda_oe,
  input wire logic o_sda_in,
  input wire logic o_bus_recovering,
  input wire logic o_mst_active,
  input wire logic o_bit_tick,
  input wire logic o_slv_release
);
  logic [4:0] cfg_ff;
  wire cfg_wr = i_reg_req.wr && i_reg_req.addr == 8'h0F && !(i_reg_req.remote && cfg_ff[2]);
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_ff <= 5'h00;
    end else if (cfg_wr) begin
      cfg_ff <= i_reg_req.wdata[4:0];
    end
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  property p_od; o_scl == 1'b0 && o_sda == 1'b0; endproperty
  a_od: assert property (p_od) else $error("open drain value not zero");
  property p_cfg_rd;
    i_reg_req.rd && i_reg_req.addr == 8'h0F |=> o_reg_rdata == {3'h0, $past(cfg_ff)};
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config readback wrong");
  property p_rsvd; i_reg_req.rd && i_reg_req.addr == 8'h10 |=> !o_reg_rdata[7]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
  property p_wd_off; cfg_ff[0] |-> !$rose(o_bus_recovering); endproperty
  a_wd_off: assert property (p_wd_off) else $error("recovery while disabled");
  property p_rec_sda; o_bus_recovering |-> !o_sda_oe; endproperty
  a_rec_sda: assert property (p_rec_sda) else $error("sda driven in recovery");
  property p_rec_start; $rose(o_bus_recovering) |-> !o_sda_in || !$past(o_sda_in); endproperty
  a_rec_start: assert property (p_rec_start) else $error("recovery with sda high");
  property p_tick;
    o_bit_tick |-> !$past(o_scl_oe) && ($past(o_mst_active) || $past(o_bus_recovering));
  endproperty
  a_tick: assert property (p_tick) else $error("tick outside high phase");
  property p_slv_rel;
    o_slv_release |-> !o_scl_oe && ($past(o_scl_oe) || $past(o_scl_oe, 2));
  endproperty
  a_slv_rel: assert property (p_slv_rel) else $error("release without stretch");
  property p_filt; $changed(o_sda_in) |-> o_sda_in == $past(i_sda); endproperty
  a_filt: assert property (p_filt) else $error("sda input unfiltered");
endmodule
bind ibt_bus_timing_ctrl ibt_chk u_chk (
  .i_mclk(i_mclk),
  .i_reset_n(i_reset_n),
  .i_reg_req(i_reg_req),
  .o_reg_rdata(o_reg_rdata),
  .i_sda(i_sda),
  .o_scl(o_scl),
  .o_sda(o_sda),
  .o_scl_oe(o_scl_oe),
  .o_sda_oe(o_sda_oe),
  .o_sda_in(o_sda_in),
  .o_bus_recovering(o_bus_recovering),
  .o_mst_active(o_mst_active),
  .o_bit_tick(o_bit_tick),
  .o_slv_release(o_slv_release)
);

// file: bench/ibt_bus_timing_ctrl_tb.sv
`timescale 1ns/100ps
module ibt_bus_timing_ctrl_tb;
  logic i_mclk = 1'b0, rst_n = 1'b0, run = 1'b0, msl = 1'b0, ssl = 1'b0;
  logic sst = 1'b0, sdr = 1'b0, hsda = 1'b0, hscl = 1'b0;
  logic rd_q = 1'b0, rd_q2 = 1'b0, want_lo = 1'b0, rec_p = 1'b0, oe_p = 1'b0, sda_p = 1'b1;
  ibt_pkg::ibt_reg_req_type req = '0;
  wire scl_w, sda_w, scl_oe, sda_oe, sda_in, scl_in, free, rec, mact, rel;
  wire [7:0] rdata;
  int fail_count = 0, n_compared = 0, seed = 32'hD3C1, lo_c = 0, sl_c = 0, wd = 0, np = 0, e;
  logic [7:0] v;
  logic [7:0] q_rd [$];
  int q_lo [$];
  int q_wd [$];
  always #20 i_mclk = ~i_mclk;
  ibt_bus_timing_ctrl #(.P_WDOG_SLOW_CYC(2000)) u_dut (.i_mclk(i_mclk), .i_reset_n(rst_n),
    .i_reg_req(req), .o_reg_rdata(rdata), .i_scl(scl_w), .o_scl(), .o_scl_oe(scl_oe),
    .i_sda(sda_w), .o_sda(), .o_sda_oe(sda_oe), .i_mst_run(run), .i_mst_sda_low(msl),
    .i_slv_sda_low(ssl), .i_slv_stretch_start(sst), .i_slv_data_ready(sdr), .o_scl_in(scl_in),
    .o_sda_in(sda_in), .o_bus_free(free), .o_bus_recovering(rec), .o_mst_active(mact),
    .o_bit_tick(), .o_slv_release(rel));
  ibt_bus_partner u_bus (.i_scl_pull(scl_oe), .i_sda_pull(sda_oe), .i_hold_scl(hscl),
    .i_hold_sda(hsda), .o_scl(scl_w), .o_sda(sda_w));
  task cyc(int n); repeat (n) @(posedge i_mclk); endtask
  task bad(string m); fail_count++; $display("unexpected at %0t: %s", $time, m); endtask
  task cmp8(logic [7:0] g, logic [7:0] x); n_compared++; if (g !== x) bad("data"); endtask
  task cmpb(logic g, logic x); n_compared++; if (g !== x) bad("flag"); endtask
  task cmpi(int g, int l, int h); n_compared++; if (g < l || g > h) bad("count"); endtask
  task close_out;
    if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task wr(logic rem, logic [7:0] a, logic [7:0] d);
    @(posedge i_mclk) req <= '{1'b1, 1'b0, rem, a, d};
    @(posedge i_mclk) req <= '0;
  endtask
  task rd(logic [7:0] a, logic [7:0] x);
    q_rd.push_back(x);
    @(posedge i_mclk) req <= '{1'b0, 1'b1, 1'b0, a, 8'h00};
    @(posedge i_mclk) req <= '0;
  endtask
  task master(int x);
    want_lo = 1'b1;
    q_lo.push_back(x);
    @(posedge i_mclk) begin run <= 1'b1; msl <= 1'b1; end
    cyc(40);
    cmpb(sda_oe, 1'b1);
    run <= 1'b0;
    // let the last bit finish with scl high before the stop
    cyc(32);
    msl <= 1'b0;
    cyc(6);
  endtask
  task wdc(logic [7:0] c, int x);
    wr(1'b0, 8'h0F, c);
    if (x > 0) q_wd.push_back(x);
    @(posedge i_mclk) hsda <= 1'b1;
    cyc(x > 0 ? x + 200 : 2300);
    if (x == 0) cmpb(rec, 1'b0);
    hsda <= 1'b0;
    cyc(20);
  endtask
  always @(posedge i_mclk) begin
    rd_q2 <= rd_q;
    rd_q <= req.rd;
  end
  always @(negedge i_mclk) begin
    if (rd_q2) cmp8(rdata, q_rd.pop_front());
    if (!scl_oe && oe_p && want_lo && mact) begin
      want_lo = 1'b0;
      e = q_lo.pop_front();
      cmpi(lo_c, e, e);
    end
    lo_c = scl_oe ? lo_c + 1 : 0;
    sl_c = sdr ? 0 : sl_c + 1;
    if (rel) begin e = q_lo.pop_front(); cmpi(sl_c, e, e); end
    wd = (sda_w !== sda_p) ? 0 : wd + 1;
    if (rec && !rec_p) begin e = q_wd.pop_front(); cmpi(wd, e, e + 10); end
    if (scl_oe && !oe_p && (rec || rec_p)) np++;
    if (!rec && rec_p) begin cmpi(np, 9, 9); np = 0; end
    rec_p = rec;
    oe_p = scl_oe;
    sda_p = sda_w;
  end
  initial begin
    cyc(30000);
    bad("timeout");
    close_out();
  end
  initial begin
    cyc(4);
    rst_n <= 1'b1;
    rd(8'h0F, 8'h00);
    rd(8'h10, 8'h17);
    rd(8'h11, 8'h82);
    rd(8'h12, 8'h82);
    rd(8'h13, 8'h00);
    rd(8'h20, 8'h00);
    wr(1'b0, 8'h11, 8'h03);
    wr(1'b0, 8'h12, 8'h05);
    master(5);
    wr(1'b0, 8'h0F, 8'h04);
    wr(1'b1, 8'h12, 8'h09);
    wr(1'b1, 8'h0F, 8'h00);
    rd(8'h12, 8'h05);
    rd(8'h0F, 8'h04);
    master(5);
    wr(1'b0, 8'h0F, 8'h00);
    v = 8'($random(seed)) & 8'h0F;
    wr(1'b1, 8'h12, v);
    rd(8'h12, v);
    master(v == 8'h00 ? 1 : v);
    wr(1'b0, 8'h12, 8'h00);
    master(1);
    wr(1'b0, 8'h12, 8'h06);
    q_lo.push_back(7);
    @(posedge i_mclk) begin sst <= 1'b1; ssl <= 1'b1; end
    @(posedge i_mclk) sst <= 1'b0;
    cyc(2);
    cmpb(sda_oe, 1'b1);
    sdr <= 1'b1;
    @(posedge i_mclk) sdr <= 1'b0;
    cyc(2);
    cmpb(scl_in, 1'b0);
    cyc(13);
    cmpb(scl_in, 1'b1);
    ssl <= 1'b0;
    cyc(8);
    // one-cycle low glitch, shorter than the filter depth
    hsda <= 1'b1;
    @(posedge i_mclk) hsda <= 1'b0;
    repeat (5) @(negedge i_mclk) cmpb(sda_in, 1'b1);
    wr(1'b0, 8'h0F, 8'h02);
    @(posedge i_mclk) hsda <= 1'b1;
    cyc(3);
    hscl <= 1'b1;
    cyc(3);
    hsda <= 1'b0;
    cyc(3);
    hscl <= 1'b0;
    cyc(1200);
    cmpb(free, 1'b0);
    cyc(100);
    cmpb(free, 1'b1);
    wdc(8'h02, 1250);
    wdc(8'h00, 2000);
    wdc(8'h03, 0);
    cmpi(q_lo.size() + q_rd.size() + q_wd.size(), 0, 0);
    close_out();
  end
endmodule

// file: src/ibt_bus_timing_ctrl.sv
// Function
// R1: with lockout set, register writes arriving from the remote side are dropped.
// R2: lockout never blocks bridged accesses to slaves on the local bus.
// R3: speed-up bit picks a 50 us watchdog interval, else about one second.
// R4: watchdog detects free or hung bus; disable bit set turns it off.
// R5: watchdog expiry with sda high marks the bus free for new transactions.
// R6: watchdog expiry with sda low drives nine clock pulses on scl.
// R7: sampled sda is held after scl falls for hold field times 50 ns.
// R8: glitches on scl and sda up to filter field times 10 ns are rejected.
// R9: master scl high phase lasts the high-duration count.
// R10: master scl low phase lasts the low-duration count.
// R11: as slave, low-duration count is the sda setup before releasing stretched scl.
// R12: timing counts run on the oscillator clock; defaults fit a fast oscillator.
// R13: watchdog restarts on any scl or sda edge, counts only while bus idle.
`timescale 1ns/100ps

module ibt_glitch_filter (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire logic i_raw,
  input wire logic [3:0] i_depth_cyc,
  output logic o_level
);
  logic [3:0] cnt_ff;
  logic [3:0] nxt_cnt;
  logic lvl_ff;
  logic nxt_lvl;
  wire differs = i_raw != lvl_ff;
  wire accept = differs && (cnt_ff >= i_depth_cyc);

  // a change must persist past the depth to be taken
  assign nxt_cnt = (!differs || accept) ? 4'h0 : cnt_ff + 4'h1; // see R8
  assign nxt_lvl = accept ? i_raw : lvl_ff; // see R8
  assign o_level = lvl_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cnt_ff <= 4'h0;
      lvl_ff <= 1'b1;
    end else begin
      cnt_ff <= nxt_cnt;
      lvl_ff <= nxt_lvl;
    end
  end
endmodule

module ibt_bus_timing_ctrl #(
  parameter int unsigned P_WDOG_SLOW_CYC = ibt_pkg::WDOG_SLOW_CYC
) (
  input wire logic i_mclk,
  input wire logic i_reset_n,
  input wire ibt_pkg::ibt_reg_req_type i_reg_req,
  output logic [7:0] o_reg_rdata,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_mst_run,
  input wire logic i_mst_sda_low,
  input wire logic i_slv_sda_low,
  input wire logic i_slv_stretch_start,
  input wire logic i_slv_data_ready,
  output logic o_scl_in,
  output logic o_sda_in,
  output logic o_bus_free,
  output logic o_bus_recovering,
  output logic o_mst_active,
  output logic o_bit_tick,
  output logic o_slv_release
);
  ibt_pkg::ibt_cfg_type cfg_ff;
  logic [3:0] filter_ff;
  logic [2:0] hold_ff;
  logic [7:0] high_ff;
  logic [7:0] low_ff;
  logic [7:0] gp_ff;
  logic [7:0] rdata_ff;
  ibt_pkg::ibt_state_type state_ff;
  ibt_pkg::ibt_state_type nxt_state;
  logic [7:0] phase_ff;
  logic [7:0] nxt_phase;
  logic rec_ff;
  logic nxt_rec;
  logic [3:0] pulses_ff;
  logic [3:0] nxt_pulses;
  logic tick_ff;
  logic scl_f;
  logic sda_f;
  logic scl_q_ff;
  logic sda_q_ff;
  logic [3:0] hold_cnt_ff;
  logic [3:0] nxt_hold_cnt;
  logic sda_held_ff;
  logic [ibt_pkg::WDOG_W-1:0] wd_cnt_ff;
  logic [ibt_pkg::WDOG_W-1:0] nxt_wd_cnt;
  logic bus_free_ff;
  logic nxt_bus_free;
  logic mst_own_ff;
  logic nxt_mst_own;
  logic stretch_ff;
  logic setup_act_ff;
  logic [7:0] setup_cnt_ff;
  logic release_ff;
  logic scl_oe_ff;
  logic sda_oe_ff;

  // register decode
  wire wr_ok = i_reg_req.wr && !(i_reg_req.remote && cfg_ff.lockout); // see R1
  wire wr_cfg = wr_ok && (i_reg_req.addr == ibt_pkg::ADDR_MASTER_BUS_CONFIG);
  wire wr_fh = wr_ok && (i_reg_req.addr == ibt_pkg::ADDR_BUS_FILTER_HOLD);
  wire wr_high = wr_ok && (i_reg_req.addr == ibt_pkg::ADDR_CLOCK_HIGH);
  wire wr_low = wr_ok && (i_reg_req.addr == ibt_pkg::ADDR_CLOCK_LOW);
  wire wr_gp = wr_ok && (i_reg_req.addr == ibt_pkg::ADDR_GP_CONTROL);
  wire [7:0] wd = i_reg_req.wdata;
  wire [7:0] rd_cfg = {3'h0, cfg_ff};
  wire [7:0] rd_fh = {1'b0, hold_ff, filter_ff};
  wire [7:0] rd_mux =
    (i_reg_req.addr == ibt_pkg::ADDR_MASTER_BUS_CONFIG) ? rd_cfg :
    (i_reg_req.addr == ibt_pkg::ADDR_BUS_FILTER_HOLD) ? rd_fh :
    (i_reg_req.addr == ibt_pkg::ADDR_CLOCK_HIGH) ? high_ff :
    (i_reg_req.addr == ibt_pkg::ADDR_CLOCK_LOW) ? low_ff :
    (i_reg_req.addr == ibt_pkg::ADDR_GP_CONTROL) ? gp_ff : 8'h00;
  wire [7:0] nxt_rdata = i_reg_req.rd ? rd_mux : rdata_ff;

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_ff <= ibt_pkg::ibt_cfg_type'(ibt_pkg::RST_MASTER_BUS_CONFIG[4:0]);
      filter_ff <= ibt_pkg::RST_FILTER;
      hold_ff <= ibt_pkg::RST_HOLD;
      high_ff <= ibt_pkg::RST_CLOCK_HIGH; // see R12
      low_ff <= ibt_pkg::RST_CLOCK_LOW; // see R12
      gp_ff <= ibt_pkg::RST_GP_CONTROL;
      rdata_ff <= 8'h00;
    end else begin
      if (wr_cfg) begin
        cfg_ff <= ibt_pkg::ibt_cfg_type'(wd[4:0]);
      end
      if (wr_fh) begin
        filter_ff <= wd[ibt_pkg::POS_FILTER +: 4];
        hold_ff <= wd[ibt_pkg::POS_HOLD +: 3];
      end
      if (wr_high) begin
        high_ff <= wd;
      end
      if (wr_low) begin
        low_ff <= wd;
      end
      if (wr_gp) begin
        gp_ff <= wd;
      end
      rdata_ff <= nxt_rdata;
    end
  end

  // filter depth and hold time in clock cycles, rounded up
  wire [7:0] filt_ns = 8'(filter_ff) * 8'(ibt_pkg::FILTER_STEP_NS);
  wire [7:0] filt_cyc8 = (filt_ns + 8'(ibt_pkg::CLK_NS - 1)) / 8'(ibt_pkg::CLK_NS);
  wire [9:0] hold_ns = 10'(hold_ff) * 10'(ibt_pkg::HOLD_STEP_NS);
  wire [9:0] hold_cyc10 = (hold_ns + 10'(ibt_pkg::CLK_NS - 1)) / 10'(ibt_pkg::CLK_NS);

  ibt_glitch_filter u_scl_filter (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_raw(i_scl),
    .i_depth_cyc(filt_cyc8[3:0]),
    .o_level(scl_f)
  );

  ibt_glitch_filter u_sda_filter (
    .i_mclk(i_mclk),
    .i_reset_n(i_reset_n),
    .i_raw(i_sda),
    .i_depth_cyc(filt_cyc8[3:0]),
    .o_level(sda_f)
  );

  // bus condition detection
  wire scl_fall = scl_q_ff && !scl_f;
  wire activity = (scl_f != scl_q_ff) || (sda_f != sda_q_ff);
  wire start_seen = scl_f && scl_q_ff && sda_q_ff && !sda_f;
  wire stop_seen = scl_f && scl_q_ff && !sda_q_ff && sda_f;

  // keep sda steady after scl falls
  assign nxt_hold_cnt = scl_fall ? hold_cyc10[3:0] :
    (hold_cnt_ff != 4'h0) ? hold_cnt_ff - 4'h1 : 4'h0; // see R7
  wire hold_busy = scl_fall || (hold_cnt_ff != 4'h0);
  wire nxt_sda_held = hold_busy ? sda_held_ff : sda_f; // see R7

  // watchdog
  wire [ibt_pkg::WDOG_W-1:0] wd_limit = cfg_ff.wd_speedup ?
    ibt_pkg::WDOG_W'(ibt_pkg::WDOG_FAST_CYC) : ibt_pkg::WDOG_W'(P_WDOG_SLOW_CYC); // see R3
  wire wd_quiet = !activity && (state_ff == ibt_pkg::ST_IDLE) && !stretch_ff; // see R13
  wire wd_run = !cfg_ff.wd_disable && wd_quiet; // see R4
  wire wd_expire = wd_run && (wd_cnt_ff >= wd_limit - ibt_pkg::WDOG_W'(1));
  assign nxt_wd_cnt = (!wd_run || wd_expire) ? '0 : wd_cnt_ff + ibt_pkg::WDOG_W'(1); // see R13

  assign nxt_bus_free = (wd_expire && sda_f) ? 1'b1 : // see R5
    stop_seen ? 1'b1 :
    start_seen ? 1'b0 : bus_free_ff;

  // new master transfers only start on a free bus or one the master still owns; lockout plays no part
  wire mst_accept = i_mst_run && (bus_free_ff || mst_own_ff) && !rec_ff; // see R2 R5
  assign nxt_mst_own = (mst_own_ff || (mst_accept && state_ff == ibt_pkg::ST_IDLE)) &&
    !(stop_seen && !i_mst_run);

  // scl phase generator
  wire low_done = (phase_ff + 8'h01) >= low_ff; // see R10
  wire high_done = (phase_ff + 8'h01) >= high_ff; // see R9
  wire last_pulse = (pulses_ff + 4'h1) == ibt_pkg::RECOVER_PULSES;

  always_comb begin
    nxt_state = state_ff;
    nxt_phase = phase_ff + 8'h01;
    nxt_rec = rec_ff;
    nxt_pulses = pulses_ff;
    case (state_ff)
      ibt_pkg::ST_IDLE: begin
        nxt_phase = 8'h00;
        if (wd_expire && !sda_f) begin
          nxt_rec = 1'b1; // see R6
          nxt_pulses = 4'h0;
          nxt_state = ibt_pkg::ST_LOW;
        end else if (mst_accept) begin
          nxt_state = ibt_pkg::ST_LOW;
        end
      end
      ibt_pkg::ST_LOW: begin
        if (low_done) begin
          nxt_phase = 8'h00;
          nxt_state = ibt_pkg::ST_HIGH_WAIT; // see R10
        end
      end
      ibt_pkg::ST_HIGH_WAIT: begin
        nxt_phase = 8'h00;
        if (scl_f) begin
          nxt_state = ibt_pkg::ST_HIGH;
        end
      end
      ibt_pkg::ST_HIGH: begin
        if (high_done) begin
          nxt_phase = 8'h00;
          if (rec_ff) begin
            nxt_pulses = pulses_ff + 4'h1;
            if (last_pulse) begin
              nxt_rec = 1'b0; // see R6
              nxt_state = ibt_pkg::ST_IDLE;
            end else begin
              nxt_state = ibt_pkg::ST_LOW;
            end
          end else if (i_mst_run) begin
            nxt_state = ibt_pkg::ST_LOW; // see R9
          end else begin
            nxt_state = ibt_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ibt_pkg::ST_IDLE;
        nxt_phase = 8'h00;
        nxt_rec = 1'b0;
      end
    endcase
  end

  wire nxt_tick = (state_ff == ibt_pkg::ST_HIGH) && high_done;

  // slave clock stretch with sda setup
  wire setup_done = setup_act_ff && ((setup_cnt_ff + 8'h01) >= low_ff); // see R11
  wire nxt_stretch = (stretch_ff || i_slv_stretch_start) && !setup_done;
  wire nxt_setup_act = (setup_act_ff || (i_slv_data_ready && stretch_ff)) && !setup_done;
  wire [7:0] nxt_setup_cnt = setup_act_ff ? setup_cnt_ff + 8'h01 : 8'h00; // see R11

  // open-drain drives
  wire nxt_scl_oe = (nxt_state == ibt_pkg::ST_LOW) || nxt_stretch;
  wire nxt_sda_oe = !nxt_rec && (i_mst_sda_low || i_slv_sda_low); // see R6

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ibt_pkg::ST_IDLE;
      phase_ff <= 8'h00;
      rec_ff <= 1'b0;
      pulses_ff <= 4'h0;
      tick_ff <= 1'b0;
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      hold_cnt_ff <= 4'h0;
      sda_held_ff <= 1'b1;
      wd_cnt_ff <= '0;
      bus_free_ff <= 1'b1;
      mst_own_ff <= 1'b0;
      stretch_ff <= 1'b0;
      setup_act_ff <= 1'b0;
      setup_cnt_ff <= 8'h00;
      release_ff <= 1'b0;
      scl_oe_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      phase_ff <= nxt_phase;
      rec_ff <= nxt_rec;
      pulses_ff <= nxt_pulses;
      tick_ff <= nxt_tick;
      scl_q_ff <= scl_f;
      sda_q_ff <= sda_f;
      hold_cnt_ff <= nxt_hold_cnt;
      sda_held_ff <= nxt_sda_held;
      wd_cnt_ff <= nxt_wd_cnt;
      bus_free_ff <= nxt_bus_free;
      mst_own_ff <= nxt_mst_own;
      stretch_ff <= nxt_stretch;
      setup_act_ff <= nxt_setup_act;
      setup_cnt_ff <= nxt_setup_cnt;
      release_ff <= setup_done;
      scl_oe_ff <= nxt_scl_oe;
      sda_oe_ff <= nxt_sda_oe;
    end
  end

  assign o_reg_rdata = rdata_ff;
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = scl_oe_ff;
  assign o_sda_oe = sda_oe_ff;
  assign o_scl_in = scl_q_ff;
  assign o_sda_in = sda_held_ff;
  assign o_bus_free = bus_free_ff;
  assign o_bus_recovering = rec_ff;
  assign o_mst_active = mst_own_ff;
  assign o_bit_tick = tick_ff;
  assign o_slv_release = release_ff;
endmodule

// file: src/ibt_pkg.sv
package ibt_pkg;
  // clock
  localparam int unsigned CLK_NS = 40;
  // register offsets
  localparam logic [7:0] ADDR_MASTER_BUS_CONFIG = 8'h0F;
  localparam logic [7:0] ADDR_BUS_FILTER_HOLD = 8'h10;
  localparam logic [7:0] ADDR_CLOCK_HIGH = 8'h11;
  localparam logic [7:0] ADDR_CLOCK_LOW = 8'h12;
  localparam logic [7:0] ADDR_GP_CONTROL = 8'h13;
  // master_bus_config fields
  localparam int unsigned BIT_WD_DISABLE = 0;
  localparam int unsigned BIT_WD_SPEEDUP = 1;
  localparam int unsigned BIT_LOCKOUT = 2;
  localparam int unsigned POS_SDA_OUT_DLY = 3;
  // bus_filter_hold_control fields
  localparam int unsigned POS_FILTER = 0;
  localparam int unsigned POS_HOLD = 4;
  // reset values
  localparam logic [7:0] RST_MASTER_BUS_CONFIG = 8'h00;
  localparam logic [3:0] RST_FILTER = 4'h7;
  localparam logic [2:0] RST_HOLD = 3'h1;
  localparam logic [7:0] RST_CLOCK_HIGH = 8'h82;
  localparam logic [7:0] RST_CLOCK_LOW = 8'h82;
  localparam logic [7:0] RST_GP_CONTROL = 8'h00;
  // field units
  localparam int unsigned FILTER_STEP_NS = 10;
  localparam int unsigned HOLD_STEP_NS = 50;
  // watchdog intervals, longest times round down
  localparam int unsigned WDOG_FAST_US = 50;
  localparam int unsigned WDOG_SLOW_S = 1;
  localparam int unsigned WDOG_FAST_CYC = (WDOG_FAST_US * 1000) / CLK_NS;
  localparam int unsigned WDOG_SLOW_CYC = (WDOG_SLOW_S * 1000000000) / CLK_NS;
  localparam int unsigned WDOG_W = 25;
  // bus recovery pulses on scl
  localparam logic [3:0] RECOVER_PULSES = 4'h9;

  typedef struct packed {
    logic [1:0] sda_out_dly;
    logic lockout;
    logic wd_speedup;
    logic wd_disable;
  } ibt_cfg_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic remote;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ibt_reg_req_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOW,
    ST_HIGH_WAIT,
    ST_HIGH
  } ibt_state_type;
endpackage
